//--- src/msh_top.sv
// Serial port, hold control and channel counter of the module, with
// an AXI4-Lite slave for software. Assumes all serial and trigger
// pins are asynchronous to clk_sys_i and far slower than it.
`timescale 1ns/10ps
`include "msh_defines.svh"

// Function
// - qualifier low data, high address
// - slot zero select high targets module
// - capture serial bit on clock rise
// - advance channel on advance clock rise
// - forward advance clock and trigger pin
// - sample state driven only when enabled
// - level pin source: follow, invert trigger
// - level trigger source: both show inverse
// - pin rise holds, flag change tracks
// - trigger fall holds, flag change tracks
// - identification shifts 32 bits then zeros
// - deselect reloads identification register
// - serial output only with jumper set
// - sample state low track, high hold
// - channel zero after reset
module msh_top (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              serial_in_line_i,
  input  wire logic              serial_shift_clock_i,
  input  wire logic              data_addr_qualifier_i,
  input  wire logic              slot_zero_select_n_i,
  input  wire logic              module_select_n_i,
  input  wire logic              channel_advance_clock_i,
  input  wire logic              freeze_trigger_pin_i,
  input  wire logic              backplane_trigger_one_i,
  output logic                   serial_out_line_o,
  output logic                   serial_out_line_oe_o,
  output logic                   backplane_trigger_zero_o,
  output logic                   backplane_trigger_one_o,
  output logic                   backplane_trigger_one_oe_o,
  output logic                   freeze_trigger_pin_o,
  output logic                   freeze_trigger_pin_oe_o,
  output logic                   sample_state_o,
  output logic                   sample_state_oe_o,
  output msh_pkg::msh_chan_type  mux_channel_o,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire msh_pkg::msh_addr_type s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire msh_pkg::msh_word_type s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire msh_pkg::msh_addr_type s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output msh_pkg::msh_word_type  s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  import msh_pkg::*;

  // Synchronisers reset to the idle pin levels so that no false edge follows reset.
  localparam logic [7:0] SYNC_IDLE = `MSH_SYNC_IDLE;

  // Pin order: clock, data, qualifier, select, slot zero, advance, pin, trigger.
  logic [7:0]   raw_in;
  logic [7:0]   meta_reg;
  logic [7:0]   sync_reg;
  logic [7:0]   prev_reg;
  logic [7:0]   rise;
  logic [7:0]   fall;
  logic         selected;
  logic         sclk_rise;
  msh_word_type ctrl_reg;
  msh_word_type cfg_reg;
  msh_word_type cfg_shift_reg;
  logic         cfg_dirty_reg;
  msh_word_type idval_reg;
  msh_word_type id_shift_reg;
  msh_chan_type chan_reg;
  logic         scan_flag_reg;
  msh_hold_type hold_reg;
  msh_hold_type hold_next;
  msh_src_type  src;
  logic         edge_mode;
  logic         wrap;
  logic         aw_full_reg;
  logic         w_full_reg;
  msh_addr_type aw_addr_reg;
  msh_word_type w_data_reg;
  msh_word_type wmask;
  msh_word_type rd_word;
  logic         rd_ok;

  assign raw_in = {backplane_trigger_one_i, freeze_trigger_pin_i,
                   channel_advance_clock_i, slot_zero_select_n_i,
                   module_select_n_i, data_addr_qualifier_i,
                   serial_in_line_i, serial_shift_clock_i};

  // Three flip-flops per pin; the first stage feeds only the second, the second and third feed the logic.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          meta_reg[gi] <= SYNC_IDLE[gi];
          sync_reg[gi] <= SYNC_IDLE[gi];
          prev_reg[gi] <= SYNC_IDLE[gi];
        end else if (ce_i) begin
          meta_reg[gi] <= raw_in[gi];
          sync_reg[gi] <= meta_reg[gi];
          prev_reg[gi] <= sync_reg[gi];
        end
      end
      assign rise[gi] = sync_reg[gi] & ~prev_reg[gi];
      assign fall[gi] = ~sync_reg[gi] & prev_reg[gi];
    end
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[8*gi +: 8] = {8{s_axi_wstrb[gi]}};
    end
  endgenerate

  // Select is active low; slot zero select high means the stream is ours.
  // module targeting
  assign selected  = ~sync_reg[3] & sync_reg[4];
  assign sclk_rise = rise[0] & selected;
  assign src       = msh_src_type'(cfg_reg[`MSH_CFG_SRC]);
  assign edge_mode = cfg_reg[`MSH_CFG_EDGE];
  assign wrap      = rise[5] && (chan_reg == `MSH_LAST_CHAN);

  // Configuration shift; the live word only changes on deselect so a
  // half-written word never steers the trigger logic.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_shift_reg <= `MSH_RST_CONFIG;
      cfg_dirty_reg <= 1'b0;
      cfg_reg       <= `MSH_RST_CONFIG;
    end else if (ce_i) begin
      if (sclk_rise && !sync_reg[2]) begin
        cfg_shift_reg <= {cfg_shift_reg[30:0], sync_reg[1]};
        cfg_dirty_reg <= 1'b1;
      end else if (rise[3] && cfg_dirty_reg) begin
        cfg_reg       <= cfg_shift_reg;
        cfg_dirty_reg <= 1'b0;
      end
    end
  end

  // Identification shift: each rise presents the next bit, zeros fill in.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      id_shift_reg         <= `MSH_RST_IDVAL;
      serial_out_line_o    <= 1'b0;
      serial_out_line_oe_o <= 1'b0;
    end else if (ce_i) begin
      serial_out_line_oe_o <= ctrl_reg[`MSH_CTRL_JUMPER] & selected;
      if (sync_reg[3]) begin
        id_shift_reg      <= idval_reg;
        serial_out_line_o <= 1'b0;
      end else if (sclk_rise && sync_reg[2]) begin
        id_shift_reg      <= {id_shift_reg[30:0], 1'b0};
        serial_out_line_o <= id_shift_reg[31];
      end
    end
  end

  // Channel counter; the flag flips each time the scan wraps.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      chan_reg      <= 3'h0;
      scan_flag_reg <= 1'b0;
    end else if (ce_i && rise[5]) begin
      chan_reg <= chan_reg + 3'h1;
      if (wrap) begin
        scan_flag_reg <= ~scan_flag_reg;
      end
    end
  end

  // Next hold state. A new trigger beats a simultaneous flag change.
  always_comb begin
    hold_next = hold_reg;
    if (!edge_mode) begin
      hold_next = (src == MSH_SRC_PIN) ? msh_hold_type'(sync_reg[6])
                                       : msh_hold_type'(~sync_reg[7]);
    end else if ((src == MSH_SRC_PIN && rise[6]) ||
                 (src == MSH_SRC_BACKPLANE_TRIGGER_ONE && fall[7])) begin
      hold_next = MSH_HOLD;
    end else if (wrap) begin
      hold_next = MSH_TRACK;
    end
  end

  // Hold and sample state, the forwarded trigger pins and the mux channel output.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hold_reg                   <= MSH_TRACK;
      sample_state_o             <= 1'b0;
      sample_state_oe_o          <= 1'b0;
      backplane_trigger_zero_o   <= 1'b0;
      backplane_trigger_one_o    <= 1'b1;
      backplane_trigger_one_oe_o <= 1'b0;
      freeze_trigger_pin_o       <= 1'b0;
      freeze_trigger_pin_oe_o    <= 1'b0;
      mux_channel_o              <= 3'h0;
    end else if (ce_i) begin
      hold_reg                   <= hold_next;
      sample_state_o             <= hold_next;
      sample_state_oe_o          <= cfg_reg[`MSH_CFG_OUT_EN];
      backplane_trigger_zero_o   <= sync_reg[5];
      backplane_trigger_one_o    <= ~sync_reg[6];
      backplane_trigger_one_oe_o <= (src == MSH_SRC_PIN);
      freeze_trigger_pin_o       <= ~sync_reg[7];
      freeze_trigger_pin_oe_o    <= (src == MSH_SRC_BACKPLANE_TRIGGER_ONE);
      mux_channel_o              <= rise[5] ? chan_reg + 3'h1 : chan_reg;
    end
  end

  // AXI write: address and data are caught in either order.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MSH_RESP_OKAY;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0000_0000;
      ctrl_reg      <= `MSH_RST_CTRL;
      idval_reg     <= `MSH_RST_IDVAL;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_full_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
      end else if (!aw_full_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_full_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata & wmask;
      end else if (!w_full_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `MSH_RESP_OKAY;
        case (aw_addr_reg)
          `MSH_OFF_CTRL:   ctrl_reg  <= w_data_reg;
          `MSH_OFF_IDVAL:  idval_reg <= w_data_reg;
          `MSH_OFF_CONFIG,
          `MSH_OFF_STATUS: s_axi_bresp <= `MSH_RESP_OKAY;
          default:         s_axi_bresp <= `MSH_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; configuration and status are read-only views.
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `MSH_OFF_CTRL:   rd_word = ctrl_reg;
      `MSH_OFF_CONFIG: rd_word = cfg_reg;
      `MSH_OFF_STATUS: rd_word = {26'h0, selected, scan_flag_reg,
                                  hold_reg, chan_reg};
      `MSH_OFF_IDVAL:  rd_word = idval_reg;
      default:         rd_ok   = 1'b0;
    endcase
  end

  // AXI read channel, one read in flight.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MSH_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `MSH_RESP_OKAY : `MSH_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Checks on the serial, channel and hold behaviour.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_CFG_SHIFT: assert property (ce_i && sclk_rise && !sync_reg[2]
    |=> cfg_shift_reg[0] == $past(sync_reg[1]))
    else $error("config bit not captured");
  AST_ID_ORDER: assert property (ce_i && sclk_rise && sync_reg[2]
    |=> serial_out_line_o == $past(id_shift_reg[31]))
    else $error("id bit out of order");
  AST_ID_RELOAD: assert property (ce_i && sync_reg[3]
    |=> id_shift_reg == $past(idval_reg))
    else $error("id not reloaded on deselect");
  AST_IGNORE: assert property (ce_i && !selected
    |=> $stable(cfg_shift_reg))
    else $error("config shifted while deselected");
  AST_APPLY: assert property (ce_i && rise[3] && cfg_dirty_reg
    |=> cfg_reg == $past(cfg_shift_reg))
    else $error("config not applied on deselect");
  AST_ADVANCE: assert property (ce_i && rise[5]
    |=> chan_reg == $past(chan_reg) + 3'h1)
    else $error("channel did not advance");
  AST_JUMPER: assert property (serial_out_line_oe_o
    |-> ctrl_reg[`MSH_CTRL_JUMPER] || $past(ctrl_reg[`MSH_CTRL_JUMPER]))
    else $error("serial out driven without jumper");
  AST_LEVEL_PIN: assert property (ce_i && !edge_mode && src == MSH_SRC_PIN
    |=> hold_reg == $past(sync_reg[6]))
    else $error("hold does not follow pin");
  AST_LEVEL_TRIG: assert property (ce_i && !edge_mode && src == MSH_SRC_BACKPLANE_TRIGGER_ONE
    |=> hold_reg == !$past(sync_reg[7]) && freeze_trigger_pin_o == !$past(sync_reg[7]))
    else $error("trigger inverse missing");
  AST_EDGE_PIN: assert property (ce_i && edge_mode && src == MSH_SRC_PIN
    && rise[6] |=> hold_reg == MSH_HOLD)
    else $error("pin rise did not hold");
  AST_EDGE_TRIG: assert property (ce_i && edge_mode && src == MSH_SRC_BACKPLANE_TRIGGER_ONE
    && fall[7] |=> hold_reg == MSH_HOLD)
    else $error("trigger fall did not hold");
  AST_FWD: assert property (ce_i |=> backplane_trigger_zero_o == $past(sync_reg[5]))
    else $error("advance clock not forwarded");

  COV_CFG_WRITE: cover property (rise[3] && cfg_dirty_reg);
  COV_ID_READ:   cover property (sclk_rise && sync_reg[2]);
  COV_WRAP:      cover property (wrap && edge_mode);
  COV_EDGE_HOLD: cover property (edge_mode && hold_next == MSH_HOLD && hold_reg == MSH_TRACK);
endmodule

//--- shared/msh_defines.svh
// Constants for the module serial and hold control block.
// Assumes inclusion by the top module and the bench.
`ifndef MSH_DEFINES_SVH
`define MSH_DEFINES_SVH
// AXI4-Lite register byte offsets.
`define MSH_OFF_CTRL    4'h0
`define MSH_OFF_CONFIG  4'h4
`define MSH_OFF_STATUS  4'h8
`define MSH_OFF_IDVAL   4'hc
// Control register fields.
`define MSH_CTRL_JUMPER 0
// Configuration word fields, as shifted in over the serial port.
`define MSH_CFG_OUT_EN  0
`define MSH_CFG_SRC     1
`define MSH_CFG_EDGE    2
// Status register fields.
`define MSH_ST_CHAN_LO  0
`define MSH_ST_HOLD     3
`define MSH_ST_SCAN     4
`define MSH_ST_SEL      5
// Reset values. The identification value is arbitrary.
`define MSH_RST_CTRL    32'h0000_0001
`define MSH_RST_CONFIG  32'h0000_0000
`define MSH_RST_IDVAL   32'h5a3c_0001
`define MSH_LAST_CHAN   3'h7
// Idle level of each synchronised pin, in synchroniser bit order.
`define MSH_SYNC_IDLE   8'h9d
`define MSH_ID_BITS     32
`define MSH_RESP_OKAY   2'h0
`define MSH_RESP_SLVERR 2'h2
`endif

//--- shared/msh_pkg.sv
// Types shared by the module serial and hold control block.
// Assumes the defines header sits beside it.
package msh_pkg;
  // Where the freeze trigger comes from.
  typedef enum logic {
    MSH_SRC_PIN   = 1'b0,
    MSH_SRC_BACKPLANE_TRIGGER_ONE = 1'b1
  } msh_src_type;
  // Sample state of the module.
  typedef enum logic {
    MSH_TRACK = 1'b0,
    MSH_HOLD  = 1'b1
  } msh_hold_type;
  typedef logic [3:0]  msh_addr_type;
  typedef logic [31:0] msh_word_type;
  typedef logic [2:0]  msh_chan_type;
endpackage

//--- bench/msh_host_model.sv
// Host and slot-zero controller model that drives the serial port pins.
// Assumes a 100 ns system clock; one link clock period is eight clocks.
`timescale 1ns/10ps
module msh_host_model #(
  parameter logic [15:0] MY_SLOT = 16'h0005
) (
  input  wire logic clk_sys_i,
  input  wire logic serial_out_line_i,
  input  wire logic serial_out_line_oe_i,
  output logic      serial_in_line_o,
  output logic      serial_shift_clock_o,
  output logic      data_addr_qualifier_o,
  output logic      slot_zero_select_n_o,
  output logic      module_select_n_o
);
  logic miso_last = 1'b0;
  // The link clock idles high and stands still between frames.
  initial begin
    serial_in_line_o = 1'b0;
    serial_shift_clock_o = 1'b1;
    data_addr_qualifier_o = 1'b1;
    slot_zero_select_n_o = 1'b1;
    module_select_n_o = 1'b1;
  end
  // data, clock low, clock high, then sample.
  // The clock is low three system clocks and high five, an 800 ns period.
  task automatic bitx(input logic b, output logic s);
    serial_in_line_o <= b;
    @(posedge clk_sys_i) serial_shift_clock_o <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    serial_shift_clock_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    // A released line reads back as the inverse of its last level.
    s = serial_out_line_oe_i ? serial_out_line_i : ~miso_last;
    miso_last = s;
  endtask
  task automatic sel(input logic [15:0] slot);
    logic s;
    @(posedge clk_sys_i) slot_zero_select_n_o <= 1'b0;
    module_select_n_o <= 1'b1;
    for (int i = 15; i >= 0; i--) bitx(slot[i], s);
    @(posedge clk_sys_i) slot_zero_select_n_o <= 1'b1;
    module_select_n_o <= (slot == MY_SLOT) ? 1'b0 : 1'b1;
    serial_in_line_o <= ~serial_in_line_o;
  endtask
  task automatic cfg(input logic [31:0] w);
    logic s;
    @(posedge clk_sys_i) data_addr_qualifier_o <= 1'b0;
    for (int i = 31; i >= 0; i--) bitx(w[i], s);
    @(posedge clk_sys_i) serial_in_line_o <= ~serial_in_line_o;
  endtask
  // identification read with four extra clocks.
  task automatic rd(output logic [35:0] r);
    @(posedge clk_sys_i) data_addr_qualifier_o <= 1'b1;
    for (int i = 35; i >= 0; i--) bitx(1'b0, r[i]);
  endtask
endmodule

//--- bench/msh_top_tb_top.sv
// Self-checking bench for the serial and hold control block.
// Assumes the host model owns the serial pins; the bench does AXI and triggers.
`timescale 1ns/10ps
`include "msh_defines.svh"
module msh_top_tb_top;
  import msh_pkg::*;
  localparam logic [15:0] SLOT = 16'h0005;
  logic clk = 1'b0, rst = 1'b1, adv = 1'b0, pin_drv = 1'b0, t1_drv = 1'b1, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  msh_addr_type awaddr = 4'h0, araddr = 4'h0;
  msh_word_type wdata = 32'h0, rdata, idv, cw;
  wire sin, sck, qual, s0n, msn;
  logic sout, sout_oe, t0, t1_o, t1_oe, pin_o, pin_oe, ss, ss_oe;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  msh_chan_type chan;
  logic [35:0] exp_q[$], seen, r;
  logic [2:0] chan_e = 3'h0;
  logic scan_e = 1'b0;
  event got;
  int bad_count = 0, tests_run = 0, cyc = 0;
  int seed = 32'h9a9f;
  // Two-way pins: the design wins while it drives, the bench otherwise.
  wire t1_w = t1_oe ? t1_o : t1_drv;
  wire pin_w = pin_oe ? pin_o : pin_drv;
  msh_top u_msh_top (.clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .serial_in_line_i(sin),
    .serial_shift_clock_i(sck), .data_addr_qualifier_i(qual), .slot_zero_select_n_i(s0n),
    .module_select_n_i(msn), .channel_advance_clock_i(adv), .freeze_trigger_pin_i(pin_w),
    .backplane_trigger_one_i(t1_w), .serial_out_line_o(sout), .serial_out_line_oe_o(sout_oe),
    .backplane_trigger_zero_o(t0), .backplane_trigger_one_o(t1_o),
    .backplane_trigger_one_oe_o(t1_oe), .freeze_trigger_pin_o(pin_o),
    .freeze_trigger_pin_oe_o(pin_oe), .sample_state_o(ss), .sample_state_oe_o(ss_oe),
    .mux_channel_o(chan), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  msh_host_model #(.MY_SLOT(SLOT)) u_msh_host_model (.clk_sys_i(clk),
    .serial_out_line_i(sout), .serial_out_line_oe_i(sout_oe), .serial_in_line_o(sin),
    .serial_shift_clock_o(sck), .data_addr_qualifier_o(qual), .slot_zero_select_n_o(s0n),
    .module_select_n_o(msn));
  initial forever #50 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic compare(input logic [35:0] s, input logic [35:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // The pause lets the watcher take each result before the next one.
  task automatic post(input logic [35:0] v);
    seen = v;
    ->got;
    #1;
  endtask
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    exp_q.push_back(e);
    post(s);
  endtask
  always @(got) compare(seen, exp_q.pop_front());
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axw(input msh_addr_type a, input msh_word_type d, input logic [1:0] er);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic axr(input msh_addr_type a, input logic [33:0] e);
    exp_q.push_back({2'h0, e});
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    post({2'h0, rresp, rdata});
  endtask
  // one advance pulse per conversion; wrap toggles the scan flag.
  task automatic pulse();
    @(posedge clk) adv <= 1'b1;
    w(6);
    chk(t0, 1'b1);
    adv <= 1'b0;
    w(6);
    chan_e++;
    chk(chan, chan_e);
    if (chan_e == 3'h0) scan_e = ~scan_e;
  endtask
  task automatic setcfg(input logic [2:0] m);
    cw = $random(seed);
    cw[2:0] = m;
    u_msh_host_model.sel(SLOT);
    u_msh_host_model.cfg(cw);
    u_msh_host_model.sel(16'h0000);
    axr(`MSH_OFF_CONFIG, {2'h0, cw});
  endtask
  initial begin
    w(10);
    rst <= 1'b0;
    w(4);
    axr(`MSH_OFF_CTRL, {`MSH_RESP_OKAY, `MSH_RST_CTRL});
    axr(`MSH_OFF_IDVAL, {`MSH_RESP_OKAY, `MSH_RST_IDVAL});
    axr(`MSH_OFF_STATUS, 34'h0);
    axr(4'h2, {`MSH_RESP_SLVERR, 32'h0});
    axw(4'h2, 32'h0, `MSH_RESP_SLVERR);
    idv = $random(seed);
    axw(`MSH_OFF_IDVAL, idv, `MSH_RESP_OKAY);
    u_msh_host_model.sel(SLOT);
    u_msh_host_model.rd(r);
    chk(r, {idv, 4'h0});
    u_msh_host_model.sel(SLOT);
    u_msh_host_model.rd(r);
    chk(r, {idv, 4'h0});
    axw(`MSH_OFF_CTRL, 32'h0, `MSH_RESP_OKAY);
    w(8);
    chk(sout_oe, 1'b0);
    axw(`MSH_OFF_CTRL, 32'h1, `MSH_RESP_OKAY);
    u_msh_host_model.sel(16'h0000);
    u_msh_host_model.cfg(32'hffff_ffff);
    axr(`MSH_OFF_CONFIG, 34'h0);
    setcfg(3'b001);
    pin_drv <= 1'b1;
    w(8);
    chk({ss, ss_oe, t1_o, t1_oe}, 4'b1101);
    pin_drv <= 1'b0;
    w(8);
    chk({ss, t1_o}, 2'b01);
    setcfg(3'b000);
    chk(ss_oe, 1'b0);
    repeat (3) pulse();
    // Clock enable low freezes the synchronisers, so this pulse is lost.
    ce <= 1'b0;
    adv <= 1'b1;
    w(6);
    chk(t0, 1'b0);
    adv <= 1'b0;
    w(6);
    ce <= 1'b1;
    w(4);
    chk(chan, chan_e);
    axr(`MSH_OFF_STATUS, 34'h3);
    setcfg(3'b011);
    t1_drv <= 1'b0;
    w(8);
    chk({ss, pin_o, pin_oe}, 3'b111);
    t1_drv <= 1'b1;
    w(8);
    chk({ss, pin_o}, 2'b00);
    setcfg(3'b101);
    pin_drv <= 1'b1;
    w(8);
    chk(ss, 1'b1);
    pin_drv <= 1'b0;
    do pulse(); while (chan_e != 3'h0);
    w(8);
    chk(ss, 1'b0);
    axr(`MSH_OFF_STATUS, {29'h0, scan_e, 4'h0});
    setcfg(3'b111);
    t1_drv <= 1'b0;
    w(8);
    chk(ss, 1'b1);
    t1_drv <= 1'b1;
    do pulse(); while (chan_e != 3'h0);
    w(8);
    chk(ss, 1'b0);
    report_and_stop();
  end
endmodule
